// [dcrb_bank.sv]
// per-channel register bank of a two-channel synthesizer, wishbone slave
//
// Implementation choice: the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
`include "dcrb_consts.svh"
module dcrb_bank
  import dcrb_pkg::*;
#(
  parameter int NUM_CH = 2
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic update_i,
  output var dcrb_core_t [NUM_CH-1:0] core_o
);
  localparam int CH_W = (NUM_CH > 1) ? $clog2(NUM_CH) : 1;

  typedef struct packed {
    dcrb_chan_t [NUM_CH-1:0] shadow;
    dcrb_chan_t [NUM_CH-1:0] active;
    logic [CH_W-1:0] ch_sel;
    logic ack;
    logic [31:0] rdata;
    logic [NUM_CH-1:0] phase_pulse;
    logic [NUM_CH-1:0] sweep_pulse;
  } dcrb_state_t;

  dcrb_state_t q;
  dcrb_state_t next_q;
  logic [5:0] widx;
  logic req;
  logic [31:0] merged;
  logic [31:0] status;
  logic [NUM_CH-1:0] tick;
  logic [NUM_CH-1:0][7:0] ramp_count;

  // ==========================================================
  // register image of one channel
  function automatic logic [31:0] reg_word(dcrb_chan_t c,
                                           logic [5:0] idx);
    logic [31:0] w;
    w = `DCRB_RESET_WORD;
    case (idx)
      `DCRB_IDX_CHAN_FN: w[`DCRB_CF_W-1:0] = c.chan_fn;
      `DCRB_IDX_FREQ: w = c.freq_tuning_word;
      `DCRB_IDX_PHASE: w[`DCRB_PH_HI:0] = c.phase_offset_word;
      `DCRB_IDX_AMP:
      begin
        w[`DCRB_AC_RATE_HI:`DCRB_AC_RATE_LO] = c.amplitude_ramp_rate;
        w[`DCRB_AC_STEP_HI:`DCRB_AC_STEP_LO] = c.ramp_step;
        w[`DCRB_AC_MULT] = c.mult_en;
        w[`DCRB_AC_AUTO] = c.amplitude_ramping;
        w[`DCRB_AC_LOAD] = c.load_rate_on_update;
        w[`DCRB_AC_SCALE_HI:0] = c.scale_factor;
      end
      `DCRB_IDX_RAMP:
      begin
        w[`DCRB_RR_FALL_HI:`DCRB_RR_FALL_LO] = c.falling_ramp_rate;
        w[`DCRB_RR_RISE_HI:0] = c.rising_ramp_rate;
      end
      `DCRB_IDX_RISE: w = c.rising_delta_word;
      `DCRB_IDX_FALL: w = c.falling_delta_word;
      default: w = `DCRB_RESET_WORD;
    endcase
    return w;
  endfunction : reg_word

  // store a word; bits outside the fields are dropped
  function automatic dcrb_chan_t reg_store(dcrb_chan_t c,
                                           logic [5:0] idx,
                                           logic [31:0] w);
    dcrb_chan_t r;
    r = c;
    case (idx)
      `DCRB_IDX_CHAN_FN: r.chan_fn = w[`DCRB_CF_W-1:0];
      `DCRB_IDX_FREQ: r.freq_tuning_word = w;
      `DCRB_IDX_PHASE: r.phase_offset_word = w[`DCRB_PH_HI:0];
      `DCRB_IDX_AMP:
      begin
        r.amplitude_ramp_rate = w[`DCRB_AC_RATE_HI:`DCRB_AC_RATE_LO];
        r.ramp_step = w[`DCRB_AC_STEP_HI:`DCRB_AC_STEP_LO];
        r.mult_en = w[`DCRB_AC_MULT];
        r.amplitude_ramping = w[`DCRB_AC_AUTO];
        r.load_rate_on_update = w[`DCRB_AC_LOAD];
        r.scale_factor = w[`DCRB_AC_SCALE_HI:0];
      end
      `DCRB_IDX_RAMP:
      begin
        r.falling_ramp_rate = w[`DCRB_RR_FALL_HI:`DCRB_RR_FALL_LO];
        r.rising_ramp_rate = w[`DCRB_RR_RISE_HI:0];
      end
      `DCRB_IDX_RISE: r.rising_delta_word = w;
      `DCRB_IDX_FALL: r.falling_delta_word = w;
      default: r = c;
    endcase
    return r;
  endfunction : reg_store

  // byte-lane merge of a write
  function automatic logic [31:0] lane_merge(logic [31:0] old_w,
                                             logic [31:0] new_w,
                                             logic [3:0] sel);
    logic [31:0] m;
    m = old_w;
    for (int b = 0; b < 4; b++)
    begin
      if (sel[b])
        m[b*8 +: 8] = new_w[b*8 +: 8];
    end
    return m;
  endfunction : lane_merge

  // ==========================================================
  // bus decode and status
  assign widx = adr_i[7:2];
  assign req = cyc_i && stb_i;

  always_comb
  begin
    status = `DCRB_RESET_WORD;
    status[7:0] = ramp_count[q.ch_sel];
    status[`DCRB_ST_SCLR] = q.active[q.ch_sel].chan_fn[`DCRB_CF_CLR_SWEEP];
    status[`DCRB_ST_PCLR] = q.active[q.ch_sel].chan_fn[`DCRB_CF_CLR_PHASE];
    status[`DCRB_ST_MULT] = q.active[q.ch_sel].mult_en;
  end

  always_comb
  begin
    if (widx == `DCRB_IDX_CH_SEL)
      merged = lane_merge(32'(q.ch_sel), dat_i, sel_i);
    else
      merged = lane_merge(reg_word(q.shadow[q.ch_sel], widx), dat_i,
                          sel_i);
  end

  // ==========================================================
  // next state
  always_comb
  begin
    next_q = q;
    next_q.ack = req && !q.ack;
    if (req && !q.ack)
    begin
      if (widx == `DCRB_IDX_CH_SEL)
        next_q.rdata = 32'(q.ch_sel);
      else if (widx == `DCRB_IDX_STATUS)
        next_q.rdata = status;
      else
        next_q.rdata = reg_word(q.shadow[q.ch_sel], widx);
    end
    // write commits at the edge that ends the cycle
    if (req && we_i && q.ack)
    begin
      if (widx == `DCRB_IDX_CH_SEL)
        next_q.ch_sel = merged[CH_W-1:0];
      else
        next_q.shadow[q.ch_sel] = reg_store(q.shadow[q.ch_sel], widx,
                                            merged);
    end
    for (int ch = 0; ch < NUM_CH; ch++)
    begin
      if (update_i)
        next_q.active[ch] = q.shadow[ch];
      next_q.sweep_pulse[ch] = update_i &&
        q.shadow[ch].chan_fn[`DCRB_CF_AUTOCLR_SWEEP];
      next_q.phase_pulse[ch] = update_i &&
        q.shadow[ch].chan_fn[`DCRB_CF_AUTOCLR_PHASE];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      q <= '0;
    else
      q <= next_q;
  end

  assign ack_o = q.ack;
  assign dat_o = q.rdata;

  // ==========================================================
  // channel outputs
  for (genvar g = 0; g < NUM_CH; g++)
  begin : g_ch
    dcrb_ramp_timer #(
      .W(8)
    ) u_timer (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .run_i(q.active[g].mult_en && q.active[g].amplitude_ramping),
      .rate_i(q.active[g].amplitude_ramp_rate),
      .load_on_update_i(q.active[g].load_rate_on_update),
      .update_i(update_i),
      .tick_o(tick[g]),
      .count_o(ramp_count[g])
    );

    always_comb
    begin
      core_o[g].freq_tuning_word = q.active[g].freq_tuning_word;
      core_o[g].phase_offset_word = q.active[g].phase_offset_word;
      core_o[g].rising_delta_word = q.active[g].rising_delta_word;
      core_o[g].falling_delta_word = q.active[g].falling_delta_word;
      core_o[g].rising_ramp_rate = q.active[g].rising_ramp_rate;
      core_o[g].falling_ramp_rate = q.active[g].falling_ramp_rate;
      core_o[g].scale_factor = q.active[g].scale_factor;
      core_o[g].ramp_step = q.active[g].ramp_step;
      core_o[g].pipe_match = q.active[g].chan_fn[`DCRB_CF_PIPE];
      core_o[g].sine_sel = q.active[g].chan_fn[`DCRB_CF_SINE];
      core_o[g].phase_clr_async = q.active[g].chan_fn[`DCRB_CF_CLR_PHASE];
      core_o[g].sweep_clr_async = q.active[g].chan_fn[`DCRB_CF_CLR_SWEEP];
      core_o[g].phase_clr_sync = q.phase_pulse[g];
      core_o[g].sweep_clr_sync = q.sweep_pulse[g];
      // clocks gated and data bypassed when off
      core_o[g].amp_clk_en = q.active[g].mult_en;
      core_o[g].amp_bypass = !q.active[g].mult_en;
      core_o[g].amp_auto = q.active[g].mult_en &&
        q.active[g].amplitude_ramping;
      core_o[g].amp_ramp_tick = tick[g];
    end
  end

  // ==========================================================
  // checks on channel 0 and the bus
  logic upd_sweep0;
  logic upd_phase0;
  assign upd_sweep0 = update_i &&
    q.shadow[0].chan_fn[`DCRB_CF_AUTOCLR_SWEEP];
  assign upd_phase0 = update_i &&
    q.shadow[0].chan_fn[`DCRB_CF_AUTOCLR_PHASE];

  property p_pipe;
    @(posedge clk_i) disable iff (rst_i)
    update_i |=> core_o[0].pipe_match ==
      $past(q.shadow[0].chan_fn[`DCRB_CF_PIPE]);
  endproperty
  a_pipe: assert property (p_pipe)
    else $error("pipe delay mode not taken on update");

  property p_sweep_pulse;
    @(posedge clk_i) disable iff (rst_i)
    ##1 (core_o[0].sweep_clr_sync == $past(upd_sweep0));
  endproperty
  a_sweep_pulse: assert property (p_sweep_pulse)
    else $error("sweep clear pulse wrong");

  property p_sweep_hold;
    @(posedge clk_i) disable iff (rst_i)
    $rose(core_o[0].sweep_clr_async) |-> $past(update_i);
  endproperty
  a_sweep_hold: assert property (p_sweep_hold)
    else $error("sweep hold clear rose without update");

  property p_phase_pulse;
    @(posedge clk_i) disable iff (rst_i)
    upd_phase0 ##1 !update_i |-> core_o[0].phase_clr_sync ##1
      !core_o[0].phase_clr_sync;
  endproperty
  a_phase_pulse: assert property (p_phase_pulse)
    else $error("phase clear pulse not one cycle");

  property p_phase_hold;
    @(posedge clk_i) disable iff (rst_i)
    $changed(core_o[0].phase_clr_async) |-> $past(update_i);
  endproperty
  a_phase_hold: assert property (p_phase_hold)
    else $error("phase hold clear changed without update");

  property p_sine;
    @(posedge clk_i) disable iff (rst_i)
    $changed(core_o[0].sine_sel) |-> $past(update_i);
  endproperty
  a_sine: assert property (p_sine)
    else $error("wave select changed without update");

  property p_bypass;
    @(posedge clk_i) disable iff (rst_i)
    update_i |=> core_o[0].amp_clk_en == $past(q.shadow[0].mult_en) &&
      core_o[0].amp_bypass != core_o[0].amp_clk_en;
  endproperty
  a_bypass: assert property (p_bypass)
    else $error("bypass and clock enable disagree");

  property p_auto;
    @(posedge clk_i) disable iff (rst_i)
    core_o[0].amp_auto |-> core_o[0].amp_clk_en;
  endproperty
  a_auto: assert property (p_auto)
    else $error("auto ramp without multiplier");

  property p_update;
    @(posedge clk_i) disable iff (rst_i)
    update_i |=> core_o[0].freq_tuning_word ==
      $past(q.shadow[0].freq_tuning_word);
  endproperty
  a_update: assert property (p_update)
    else $error("update did not move tuning word");

  property p_unused_zero;
    @(posedge clk_i) disable iff (rst_i)
    (ack_o && !we_i && widx == `DCRB_IDX_CHAN_FN) |->
      dat_o[31:`DCRB_CF_W] == '0;
  endproperty
  a_unused_zero: assert property (p_unused_zero)
    else $error("unused function bits read nonzero");

  property p_ack_once;
    @(posedge clk_i) disable iff (rst_i)
    ack_o |=> !ack_o;
  endproperty
  a_ack_once: assert property (p_ack_once)
    else $error("ack held longer than one cycle");

  c_write: cover property (@(posedge clk_i) disable iff (rst_i)
    ack_o && we_i && widx == `DCRB_IDX_FREQ);
  c_autoclr: cover property (@(posedge clk_i) disable iff (rst_i)
    core_o[0].phase_clr_sync);
  c_auto_ramp: cover property (@(posedge clk_i) disable iff (rst_i)
    core_o[0].amp_auto && core_o[0].amp_ramp_tick);
endmodule : dcrb_bank
`default_nettype wire

// [dcrb_consts.svh]
// register indices, field positions and reset values of the channel bank
`ifndef DCRB_CONSTS_SVH
`define DCRB_CONSTS_SVH
// word indices; byte address is four times the index
`define DCRB_IDX_CH_SEL 6'h00
`define DCRB_IDX_CHAN_FN 6'h03
`define DCRB_IDX_FREQ 6'h04
`define DCRB_IDX_PHASE 6'h05
`define DCRB_IDX_AMP 6'h06
`define DCRB_IDX_RAMP 6'h07
`define DCRB_IDX_RISE 6'h08
`define DCRB_IDX_FALL 6'h09
`define DCRB_IDX_STATUS 6'h0a
// channel function bits
`define DCRB_CF_PIPE 5
`define DCRB_CF_AUTOCLR_SWEEP 4
`define DCRB_CF_CLR_SWEEP 3
`define DCRB_CF_AUTOCLR_PHASE 2
`define DCRB_CF_CLR_PHASE 1
`define DCRB_CF_SINE 0
`define DCRB_CF_W 6
// phase offset word field
`define DCRB_PH_HI 13
// amplitude control fields
`define DCRB_AC_RATE_HI 23
`define DCRB_AC_RATE_LO 16
`define DCRB_AC_STEP_HI 15
`define DCRB_AC_STEP_LO 14
`define DCRB_AC_MULT 12
`define DCRB_AC_AUTO 11
`define DCRB_AC_LOAD 10
`define DCRB_AC_SCALE_HI 9
// sweep ramp rate fields
`define DCRB_RR_FALL_HI 15
`define DCRB_RR_FALL_LO 8
`define DCRB_RR_RISE_HI 7
// status fields
`define DCRB_ST_MULT 10
`define DCRB_ST_PCLR 9
`define DCRB_ST_SCLR 8
// reset value of every register
`define DCRB_RESET_WORD 32'h0000_0000
`endif

// [dcrb_pkg.sv]
// types shared by the channel register bank
`default_nettype none
package dcrb_pkg;
  // one channel's register contents
  typedef struct packed {
    logic [5:0] chan_fn;
    logic [31:0] freq_tuning_word;
    logic [13:0] phase_offset_word;
    logic [7:0] amplitude_ramp_rate;
    logic [1:0] ramp_step;
    logic mult_en;
    logic amplitude_ramping;
    logic load_rate_on_update;
    logic [9:0] scale_factor;
    logic [7:0] falling_ramp_rate;
    logic [7:0] rising_ramp_rate;
    logic [31:0] rising_delta_word;
    logic [31:0] falling_delta_word;
  } dcrb_chan_t;

  // controls driven into one synthesizer channel
  typedef struct packed {
    logic [31:0] freq_tuning_word;
    logic [13:0] phase_offset_word;
    logic [31:0] rising_delta_word;
    logic [31:0] falling_delta_word;
    logic [7:0] rising_ramp_rate;
    logic [7:0] falling_ramp_rate;
    logic [9:0] scale_factor;
    logic [1:0] ramp_step;
    logic pipe_match;
    logic sine_sel;
    logic phase_clr_async;
    logic sweep_clr_async;
    logic phase_clr_sync;
    logic sweep_clr_sync;
    logic amp_clk_en;
    logic amp_bypass;
    logic amp_auto;
    logic amp_ramp_tick;
  } dcrb_core_t;
endpackage : dcrb_pkg
`default_nettype wire

// [dcrb_ramp_timer.sv]
// amplitude ramp rate timer of one channel
`timescale 1ns/1ps
`default_nettype none
module dcrb_ramp_timer #(
  parameter int W = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic run_i,
  input wire logic [W-1:0] rate_i,
  input wire logic load_on_update_i,
  input wire logic update_i,
  output logic tick_o,
  output logic [W-1:0] count_o
);
  typedef struct packed {
    logic [W-1:0] cnt;
  } dcrb_tmr_state_t;

  dcrb_tmr_state_t q;
  dcrb_tmr_state_t next_q;
  logic timeout;

  // ==========================================================
  // countdown
  always_comb
  begin
    next_q = q;
    timeout = run_i && (q.cnt <= W'(1));
    if (!run_i)
      next_q.cnt = rate_i;
    else if (timeout || (load_on_update_i && update_i))
      next_q.cnt = rate_i;
    else
      next_q.cnt = q.cnt - W'(1);
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      q <= '0;
    else
      q <= next_q;
  end

  assign tick_o = timeout;
  assign count_o = q.cnt;

  // ==========================================================
  // checks
  property p_reload_timeout;
    @(posedge clk_i) disable iff (rst_i)
    (run_i && q.cnt == W'(1)) |=> (q.cnt == $past(rate_i));
  endproperty
  a_reload_timeout: assert property (p_reload_timeout)
    else $error("ramp timer did not reload on timeout");

  property p_no_update_reload;
    @(posedge clk_i) disable iff (rst_i)
    (run_i && !load_on_update_i && q.cnt > W'(2)) |=>
      (q.cnt == $past(q.cnt) - W'(1));
  endproperty
  a_no_update_reload: assert property (p_no_update_reload)
    else $error("ramp timer reloaded without timeout");

  c_tick: cover property (@(posedge clk_i) disable iff (rst_i) tick_o);
endmodule : dcrb_ramp_timer
`default_nettype wire

// [dcrb_host_model.sv]
// host model driving the channel bank over wishbone
`timescale 1ns/1ps
`default_nettype none
module dcrb_host_model (
  input wire logic clk_i,
  input wire logic ack_i,
  input wire logic [31:0] dat_i,
  output logic cyc_o,
  output logic stb_o,
  output logic we_o,
  output logic [7:0] adr_o,
  output logic [3:0] sel_o,
  output logic [31:0] dat_o,
  output logic update_o
);
  // ========================================
  // idle levels
  initial
  begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o = 1'b0;
    adr_o = 8'h00;
    sel_o = 4'h0;
    dat_o = 32'h0000_0000;
    update_o = 1'b0;
  end

  // ========================================
  // single classic cycle, held until ack
  task automatic xfer(input logic we, input logic [7:0] adr,
    input logic [31:0] wd, input logic [3:0] sel,
    output logic [31:0] rd);
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o <= we;
    adr_o <= adr;
    sel_o <= sel;
    dat_o <= wd;
    do
      @(posedge clk_i);
    while (ack_i !== 1'b1);
    rd = dat_i;
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    we_o <= 1'b0;
    // released lines show no stale value
    adr_o <= ~adr;
    sel_o <= ~sel;
    dat_o <= ~wd;
  endtask : xfer

  // ========================================
  // update after writes
  task automatic set_update(input logic v);
    @(posedge clk_i);
    update_o <= v;
  endtask : set_update
endmodule : dcrb_host_model
`default_nettype wire

// [dcrb_bank_tb.sv]
// self-checking bench of the channel register bank
`timescale 1ns/1ps
`default_nettype none
module dcrb_bank_tb
  import dcrb_pkg::*;
;
  logic clk_i, rst_i, cyc, stb, we, ack, update;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, x;
  dcrb_core_t [1:0] core;
  int fail_count = 0;
  int n_compared = 0;
  int cycles = 0;
  int n;
  logic [7:0] radr [0:7] = '{8'h0c, 8'h10, 8'h14, 8'h18,
    8'h1c, 8'h20, 8'h24, 8'h2c};
  logic [31:0] rmask [0:7] = '{32'h3f, 32'hffffffff, 32'h3fff,
    32'hffdfff, 32'hffff, 32'hffffffff, 32'hffffffff, 32'h0};
  logic [5:0] cf [0:3] = '{6'h14, 6'h0a, 6'h21, 6'h00};
  logic [15:0] ac [0:3] = '{16'h0800, 16'h1000, 16'h1800, 16'h0000};

  dcrb_bank #(.NUM_CH(2)) dcrb_bank_inst (.clk_i(clk_i), .rst_i(rst_i),
    .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel),
    .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .update_i(update),
    .core_o(core));
  dcrb_host_model dcrb_host_model_inst (.clk_i(clk_i), .ack_i(ack),
    .dat_i(rdat), .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr),
    .sel_o(sel), .dat_o(wdat), .update_o(update));

  // ========================================
  // clock and hang guard
  initial
  begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  always @(posedge clk_i)
  begin
    cycles <= cycles + 1;
    if (cycles == 4000)
    begin
      fail_count = fail_count + 1;
      give_verdict();
    end
  end

  // ========================================
  // helpers
  task automatic give_verdict();
    if (fail_count == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared = n_compared + 1;
    if (seen !== exp)
    begin
      fail_count = fail_count + 1;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  function automatic logic [31:0] dv(input logic [7:0] a);
    return 32'h9abcdef7 ^ {4{a}};
  endfunction : dv

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    dcrb_host_model_inst.xfer(1'b1, a, d, 4'hf, x);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    dcrb_host_model_inst.xfer(1'b0, a, 32'h0, 4'hf, x);
    check(x, e);
  endtask : rd_chk

  task automatic upd();
    dcrb_host_model_inst.set_update(1'b1);
    dcrb_host_model_inst.set_update(1'b0);
    #1;
  endtask : upd

  task automatic rst_chk();
    #1;
    check(core[0].freq_tuning_word, 32'h0);
    check(core[1].amp_bypass, 1'b1);
    check(core[0].amp_clk_en, 1'b0);
    check(core[0].sine_sel, 1'b0);
    check(core[0].pipe_match, 1'b0);
    rd_chk(8'h0c, 32'h0);
    rd_chk(8'h18, 32'h0);
  endtask : rst_chk

  // ticks of channel 0 over 30 cycles, update held high
  task automatic count_ticks();
    dcrb_host_model_inst.set_update(1'b1);
    repeat (5) @(posedge clk_i);
    n = 0;
    repeat (30)
    begin
      @(posedge clk_i);
      if (core[0].amp_ramp_tick === 1'b1)
        n = n + 1;
    end
    dcrb_host_model_inst.set_update(1'b0);
  endtask : count_ticks

  // ========================================
  // main sequence
  initial
  begin
    rst_i = 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rst_chk();
    for (int i = 0; i < 8; i++)
    begin
      wr(radr[i], dv(radr[i]));
      rd_chk(radr[i], dv(radr[i])&rmask[i]);
    end
    check(core[0].freq_tuning_word, 32'h0);
    dcrb_host_model_inst.xfer(1'b1, 8'h10, 32'h0, 4'b0010, x);
    rd_chk(8'h10, dv(8'h10) & 32'hffff00ff);
    upd();
    check(core[0].freq_tuning_word, dv(8'h10) & 32'hffff00ff);
    check(core[0].phase_offset_word, dv(8'h14) & 32'h3fff);
    check(core[0].scale_factor, dv(8'h18) & 32'h3ff);
    check(core[0].ramp_step, dv(8'h18) >> 14 & 32'h3);
    check(core[0].rising_ramp_rate, dv(8'h1c) & 32'hff);
    check(core[0].falling_ramp_rate, dv(8'h1c) >> 8 & 32'hff);
    check(core[0].rising_delta_word, dv(8'h20));
    check(core[0].falling_delta_word, dv(8'h24));
    check(core[1].freq_tuning_word, 32'h0);
    for (int i = 0; i < 4; i++)
    begin
      wr(8'h0c, {26'h0, cf[i]});
      wr(8'h18, {16'h0, ac[i]});
      upd();
      check(core[0].pipe_match, cf[i][5]);
      check(core[0].sweep_clr_sync, cf[i][4]);
      check(core[0].sweep_clr_async, cf[i][3]);
      check(core[0].phase_clr_sync, cf[i][2]);
      check(core[0].phase_clr_async, cf[i][1]);
      check(core[0].sine_sel, cf[i][0]);
      check(core[0].amp_clk_en, ac[i][12]);
      check(core[0].amp_bypass, !ac[i][12]);
      check(core[0].amp_auto, ac[i][12] & ac[i][11]);
      @(posedge clk_i);
      #1;
      check({core[0].sweep_clr_sync, core[0].phase_clr_sync}, 2'b00);
      rd_chk(8'h28, {21'h0, ac[i][12], cf[i][1], cf[i][3], 8'h00});
    end
    // rate 3 with auto ramping: one tick every third cycle
    wr(8'h18, 32'h0003_1800);
    count_ticks();
    check(32'(n), 32'd10);
    wr(8'h18, 32'h0003_1c00);
    count_ticks();
    check(32'(n), 32'd0);
    wr(8'h00, 32'h1);
    wr(8'h10, 32'h1234_5678);
    upd();
    check(core[1].freq_tuning_word, 32'h1234_5678);
    check(core[0].freq_tuning_word, dv(8'h10) & 32'hffff00ff);
    rd_chk(8'h00, 32'h1);
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rst_chk();
    give_verdict();
  end
endmodule : dcrb_bank_tb
`default_nettype wire
